// ---- pkg/codec_ctl_pkg.sv ----
// constants shared by the codec control ends and their link
// assumes a 50 MHz system clock on both ends
package codec_ctl_pkg;
  // --------------------------------------------------------
  // clock and sequencing
  // --------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SEQ_KHZ = 256;  // internal sequencing clock
  localparam int FRAME_KHZ = 8;  // frame sync rate
  localparam logic [5:0] TICKS_PER_FRAME = 6'(SEQ_KHZ / FRAME_KHZ);
  localparam int IDLE_FRAMES = 4;  // frames of idle syncs before power-down
  localparam logic [7:0] IDLE_TICKS = 8'(IDLE_FRAMES * (SEQ_KHZ / FRAME_KHZ));
  localparam logic [1:0] PWRUP_FRAMES = 2'h2;  // syncs with output held off
  localparam logic [1:0] MISS_FRAMES = 2'h2;  // syncs without receive sync
  localparam int STILL_NS = 20000;  // bit clock still this long = held
  localparam logic [10:0] STILL_CYC = 11'((STILL_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  // master clock edges per frame that the prescaler accepts
  localparam logic [9:0] MCLK_RATIOS [7] = '{10'h020, 10'h040, 10'h0c0, 10'h0c1,
                                             10'h100, 10'h140, 10'h200};
  localparam int RATIO_SHIFT = 5;  // edges per frame / ticks per frame
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [3:0] B2_SKIP = 4'h8;  // bit slots before the second b channel
  // --------------------------------------------------------
  // link pins as seen by the device synchroniser
  // --------------------------------------------------------
  localparam int NPINS = 10;
  localparam int P_MCLK = 0, P_FST = 1, P_FSR = 2, P_BCT = 3, P_BCR = 4;
  localparam int P_PDN = 5, P_LAW = 6, P_PAI = 7, P_DR = 8, P_TIN = 9;
  localparam logic [1:0] STRAP_LOW = 2'h1, STRAP_HIGH = 2'h2;
  typedef enum logic [1:0] {MODE_FRAME_SYNC, MODE_FIRST_ISDN, MODE_GCI} timing_mode_t;
  // --------------------------------------------------------
  // controller registers on apb
  // --------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000, TXW_OFS = 12'h004;
  localparam logic [11:0] RXW_OFS = 12'h008, STAT_OFS = 12'h00c;
  localparam int C_PDN = 0, C_LAW = 1, C_TIN = 2, C_PAI = 4, C_FS_EN = 5, C_B2 = 6, C_BCR = 7;
  localparam logic [8:0] CTRL_RESET = 9'h023;
  localparam logic [4:0] BCLK_HALF = 5'h0c;  // system clocks per bit clock half
  localparam logic [7:0] LAST_BIT = 8'hff;  // bit slots per frame minus one
endpackage : codec_ctl_pkg

// ---- pkg/codec_link_if.sv ----
// link between the timing controller and the codec control
// assumes both ends run from the same system clock
`timescale 1ns/1ns
`default_nettype none
interface codec_link_if;
  logic       mclk;
  logic       tx_frame_sync;
  logic       rx_frame_sync;
  logic       tx_bit_clock;
  logic       rx_bit_clock;
  logic       power_down_n;
  logic       law_select;
  logic [1:0] tx_amp_noninv_in;  // 0 analog, 1 strapped low, 2 strapped high
  logic       power_amp_in;
  logic       rx_serial_in;
  logic       tx_serial_out;
  logic       tx_serial_oe;
  modport device (input mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock,
                  power_down_n, law_select, tx_amp_noninv_in, power_amp_in, rx_serial_in,
                  output tx_serial_out, tx_serial_oe);
  modport host (output mclk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock,
                power_down_n, law_select, tx_amp_noninv_in, power_amp_in, rx_serial_in,
                input tx_serial_out, tx_serial_oe);
endinterface : codec_link_if
`default_nettype wire

// ---- core/pin_sync.sv ----
// three-stage pin synchroniser with agreed level and edge pulses
// assumes asynchronous pins and one system clock
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // pins and result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] lvl_out,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;
  sync_t st_r, st_nxt;
  logic [W-1:0] agree;
  // level moves only when the second and third stage agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (agree[i]) begin
        st_nxt.lvl[i] = st_r.s2[i];
      end
    end
  end
  assign agree = ~(st_r.s2 ^ st_r.s3);
  assign rise_out = agree & st_r.s2 & ~st_r.lvl;
  assign fall_out = agree & ~st_r.s2 & st_r.lvl;
  assign lvl_out = st_r.lvl;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- core/codec_ctl_device.sv ----
// digital control of the codec: law, power sequencing, prescaler, pcm shifting
// assumes link pins arrive asynchronously and are sampled on clk_in
//
// How it works
// R1: law pin picks mu-law or a-law both ways
// R2: power-down input low gates clocks, floats outputs
// R3: transmit data floats two frames after power-up
// R4: strap high: amp off, amp output feeds filter
// R5: strap low: amp off, inverting input feeds filter
// R6: power amp strap high floats both drivers
// R7: receive sync idle mutes receive to mid-reference; the code mutes only in frame sync mode
// R8: prescaler divides accepted master clocks to 256 kHz
// R9: host aligns slow master clock with frame sync
// R10: host should align fast master clock too
// R11: frame sync times each transmitted pcm word
// R12: both syncs idle several frames powers down
// R13: transmit bit clock shifts; isdn also receive
// R14: host keeps bit clock within mode range
// R15: receive bit clock level selects timing mode
// R16: isdn receive sync level picks b channel
// R17: wake needs power-down high plus clocks, syncs
// R18: prescaler behaves alike in every mode
// R19: one power-down state from input or idle
// R20: idle counter counts ticks, cleared by syncs
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module codec_ctl_device
  import codec_ctl_pkg::*;
(
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  // link
  codec_link_if.device link,
  // pcm words
  input  wire logic [7:0] tx_word_in,
  output logic            tx_word_taken_out,
  output logic [7:0]      rx_word_out,
  output logic            rx_word_valid_out,
  // analog control
  output logic         mu_law_out,
  output logic         clocks_en_out,
  output logic         analog_out_en_out,
  output logic         mid_ref_pullup_out,
  output logic         tx_amp_drive_en_out,
  output logic         tx_filter_from_tg_out,
  output logic         power_amp_en_out,
  output logic         rx_filter_to_mid_out,
  // status
  output logic         seq_tick_out,
  output logic         prescaler_locked_out,
  output logic [4:0]   prescale_div_out,
  output timing_mode_t timing_mode_out,
  output logic         b2_select_out
);
  typedef struct packed {
    logic [9:0]  mc_cnt;    // master clock edges this frame
    logic [4:0]  div;       // edges per sequencing tick
    logic [4:0]  phase;
    logic        locked;
    logic        tick;
    logic [7:0]  idle_cnt;
    logic [1:0]  pwrup;     // frame syncs seen since power-up
    logic [10:0] still;     // cycles since receive bit clock moved
    logic [1:0]  miss;      // frame syncs without receive sync
    logic        tx_arm;
    logic [3:0]  tx_skip;
    logic [3:0]  tx_cnt;
    logic [7:0]  tx_sh;
    logic        dt;
    logic        dt_oe;
    logic        taken;
    logic        rx_arm;
    logic [3:0]  rx_skip;
    logic [3:0]  rx_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_word;
    logic        rx_vld;
  } dev_t;
  dev_t st_r, st_nxt;
  logic [NPINS-1:0] lvl, rise, fall;
  logic [NPINS-1:0] pins;
  logic             pd_state;
  logic             isdn;
  logic             ratio_ok;
  timing_mode_t     mode;
  // --------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------
  // link inputs enter through three flip-flops; the amp strap outputs decode tx_amp_noninv_in unsynchronised
  always_comb begin
    pins = '0;
    pins[P_MCLK] = link.mclk;
    pins[P_FST] = link.tx_frame_sync;
    pins[P_FSR] = link.rx_frame_sync;
    pins[P_BCT] = link.tx_bit_clock;
    pins[P_BCR] = link.rx_bit_clock;
    pins[P_PDN] = link.power_down_n;
    pins[P_LAW] = link.law_select;
    pins[P_PAI] = link.power_amp_in;
    pins[P_DR] = link.rx_serial_in;
    pins[P_TIN] = link.tx_amp_noninv_in == STRAP_HIGH;
  end
  pin_sync #(.W(NPINS)) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pin_in   (pins),
    .lvl_out  (lvl),
    .rise_out (rise),
    .fall_out (fall)
  );
  // --------------------------------------------------------
  // mode and power decode
  // --------------------------------------------------------
  // a still receive bit clock picks an isdn mode by its level
  always_comb begin
    if (st_r.still != STILL_CYC) begin
      mode = MODE_FRAME_SYNC;  // R15
    end else if (lvl[P_BCR]) begin
      mode = MODE_FIRST_ISDN;  // R15
    end else begin
      mode = MODE_GCI;  // R15
    end
  end
  assign isdn = mode != MODE_FRAME_SYNC;
  assign pd_state = !lvl[P_PDN] || st_r.idle_cnt == IDLE_TICKS;  // R19 R12 R2
  // frame length in master clock edges must be an accepted one
  always_comb begin
    ratio_ok = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (st_r.mc_cnt == MCLK_RATIOS[i]) begin
        ratio_ok = 1'b1;  // R8
      end
    end
  end
  // --------------------------------------------------------
  // next state
  // --------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.taken = 1'b0;
    st_nxt.rx_vld = 1'b0;
    // prescaler, same in all modes; frame sync realigns the divider
    if (rise[P_FST]) begin
      st_nxt.locked = ratio_ok;  // R8 R18
      st_nxt.div = st_r.mc_cnt[RATIO_SHIFT+4:RATIO_SHIFT];  // R8
      // an aligned master clock edge in the sync cycle opens the new frame
      st_nxt.mc_cnt = {9'h000, rise[P_MCLK]};
      st_nxt.phase = {4'h0, rise[P_MCLK]};
    end else if (rise[P_MCLK]) begin
      if (st_r.mc_cnt != 10'h3ff) begin
        st_nxt.mc_cnt = st_r.mc_cnt + 10'h001;
      end
      if (st_r.locked && st_r.phase + 5'h01 >= st_r.div) begin
        st_nxt.phase = '0;
        st_nxt.tick = 1'b1;  // R8
      end else begin
        st_nxt.phase = st_r.phase + 5'h01;
      end
    end
    // idle sync detector on sequencing ticks
    if (lvl[P_FST] || lvl[P_FSR]) begin
      st_nxt.idle_cnt = '0;  // R20
    end else if (st_r.tick && st_r.idle_cnt != IDLE_TICKS) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;  // R20 R12
    end
    // power-up hold-off counted in frame syncs
    if (pd_state) begin
      st_nxt.pwrup = '0;  // R2
    end else if (rise[P_FST] && st_r.pwrup != PWRUP_FRAMES) begin
      st_nxt.pwrup = st_r.pwrup + 2'h1;  // R3
    end
    // receive bit clock activity
    if (rise[P_BCR] || fall[P_BCR]) begin
      st_nxt.still = '0;
    end else if (st_r.still != STILL_CYC) begin
      st_nxt.still = st_r.still + 11'h001;
    end
    // half-channel: transmit syncs arrive without receive syncs
    if (rise[P_FSR]) begin
      st_nxt.miss = '0;  // R7
    end else if (rise[P_FST] && st_r.miss != MISS_FRAMES) begin
      st_nxt.miss = st_r.miss + 2'h1;  // R7
    end
    // transmit shifter, armed by the transmit frame sync
    if (rise[P_FST]) begin
      st_nxt.tx_arm = 1'b1;  // R11
      st_nxt.tx_skip = (isdn && lvl[P_FSR]) ? B2_SKIP : 4'h0;  // R16
      st_nxt.tx_cnt = '0;
      st_nxt.tx_sh = tx_word_in;
      st_nxt.taken = 1'b1;
    end else if (rise[P_BCT] && st_r.tx_arm) begin
      if (st_r.tx_skip != 4'h0) begin
        st_nxt.tx_skip = st_r.tx_skip - 4'h1;
      end else if (st_r.tx_cnt == WORD_BITS) begin
        st_nxt.tx_arm = 1'b0;
        st_nxt.dt_oe = 1'b0;
      end else begin
        st_nxt.dt = st_r.tx_sh[7];  // R13
        st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
        st_nxt.dt_oe = st_r.pwrup == PWRUP_FRAMES;  // R3
      end
    end
    if (pd_state) begin
      st_nxt.dt_oe = 1'b0;  // R2
      st_nxt.tx_arm = 1'b0;
    end
    // receive shifter: own clock and sync, or transmit ones in isdn
    if (isdn ? rise[P_FST] : rise[P_FSR]) begin
      st_nxt.rx_arm = !pd_state;  // R13
      st_nxt.rx_skip = (isdn && lvl[P_FSR]) ? B2_SKIP : 4'h0;  // R16
      st_nxt.rx_cnt = '0;
    end else if ((isdn ? fall[P_BCT] : fall[P_BCR]) && st_r.rx_arm) begin
      if (st_r.rx_skip != 4'h0) begin
        st_nxt.rx_skip = st_r.rx_skip - 4'h1;
      end else begin
        st_nxt.rx_sh = {st_r.rx_sh[6:0], lvl[P_DR]};
        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
        if (st_r.rx_cnt == WORD_BITS - 4'h1) begin
          st_nxt.rx_arm = 1'b0;
          st_nxt.rx_word = {st_r.rx_sh[6:0], lvl[P_DR]};
          st_nxt.rx_vld = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // --------------------------------------------------------
  // outputs
  // --------------------------------------------------------
  // link data and pcm words
  assign link.tx_serial_out = st_r.dt;
  assign link.tx_serial_oe = st_r.dt_oe;  // R2 R3
  assign tx_word_taken_out = st_r.taken;
  assign rx_word_out = st_r.rx_word;
  assign rx_word_valid_out = st_r.rx_vld;
  // analog enables follow the one power-down state; law, filter source and mute do not
  assign mu_law_out = lvl[P_LAW];  // R1
  assign clocks_en_out = !pd_state;  // R2
  assign analog_out_en_out = !pd_state;  // R2
  assign mid_ref_pullup_out = pd_state;
  assign tx_amp_drive_en_out = !pd_state && link.tx_amp_noninv_in == 2'h0;  // R4 R5
  assign tx_filter_from_tg_out = link.tx_amp_noninv_in != STRAP_LOW;  // R4 R5
  assign power_amp_en_out = !pd_state && !lvl[P_PAI];  // R6
  assign rx_filter_to_mid_out = mode == MODE_FRAME_SYNC && st_r.miss == MISS_FRAMES;  // R7
  // status
  assign seq_tick_out = st_r.tick && !pd_state;  // R2
  assign prescaler_locked_out = st_r.locked;
  assign prescale_div_out = st_r.div;
  assign timing_mode_out = mode;
  assign b2_select_out = isdn && lvl[P_FSR];  // R16
endmodule : codec_ctl_device
`default_nettype wire

// ---- core/codec_timing_host.sv ----
// pcm timing controller driving the codec link, set up over apb
// assumes an apb master on clk_in; one frame is 256 bit slots
`timescale 1ns/1ns
`default_nettype none
module codec_timing_host
  import codec_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // apb slave
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // link
  codec_link_if.host       link
);
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [7:0]  txw;
    logic [7:0]  rxw;
    logic        rx_flag;
    logic [31:0] prdata;
    logic [4:0]  div;
    logic        bclk;
    logic [7:0]  slot;
    logic [7:0]  dr_sh;
    logic        dr;
    logic [3:0]  cap_cnt;
    logic [7:0]  cap_sh;
  } host_t;
  host_t st_r, st_nxt;
  logic [1:0] dt_lvl;
  logic       mapped;
  logic       wr;
  logic       b2;
  pin_sync #(.W(2)) u_dt_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pin_in   ({link.tx_serial_oe, link.tx_serial_out}),
    .lvl_out  (dt_lvl),
    .rise_out (),
    .fall_out ()
  );
  assign mapped = paddr_in[11:4] == 8'h00 && paddr_in[1:0] == 2'h0;
  assign wr = psel_in && penable_in && pwrite_in && mapped;
  assign b2 = st_r.ctrl[C_B2];
  // --------------------------------------------------------
  // registers, bit clock and frame timing
  // --------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // read data latched in the setup cycle
    if (psel_in && !penable_in) begin
      case (paddr_in)
        CTRL_OFS: st_nxt.prdata = {23'h0, st_r.ctrl};
        TXW_OFS:  st_nxt.prdata = {24'h0, st_r.txw};
        RXW_OFS:  st_nxt.prdata = {24'h0, st_r.rxw};
        STAT_OFS: st_nxt.prdata = {31'h0, st_r.rx_flag};
        default:  st_nxt.prdata = '0;
      endcase
    end
    if (wr && paddr_in == CTRL_OFS) begin
      st_nxt.ctrl = pwdata_in[8:0];
    end
    if (wr && paddr_in == TXW_OFS) begin
      st_nxt.txw = pwdata_in[7:0];
    end
    if (wr && paddr_in == STAT_OFS && pwdata_in[0]) begin
      st_nxt.rx_flag = 1'b0;
    end
    // bit clock divider; slots advance on the rising edge
    if (st_r.div == BCLK_HALF - 5'h01) begin
      st_nxt.div = '0;
      st_nxt.bclk = !st_r.bclk;
      if (!st_r.bclk) begin
        st_nxt.slot = st_r.slot + 8'h01;
        if (st_r.slot == LAST_BIT) begin
          st_nxt.dr_sh = st_r.txw;
        end
        if (st_nxt.slot >= {4'h0, (b2 ? B2_SKIP : 4'h0)}) begin
          st_nxt.dr = st_nxt.dr_sh[7];  // a word loaded this slot goes out at once when b2 is clear
          st_nxt.dr_sh = {st_nxt.dr_sh[6:0], 1'b0};
        end
      end else if (dt_lvl[1]) begin
        // capture device output on falling edges while it drives
        st_nxt.cap_sh = {st_r.cap_sh[6:0], dt_lvl[0]};
        st_nxt.cap_cnt = st_r.cap_cnt + 4'h1;
        if (st_r.cap_cnt == WORD_BITS - 4'h1) begin
          st_nxt.cap_cnt = '0;
          st_nxt.rxw = {st_r.cap_sh[6:0], dt_lvl[0]};
          st_nxt.rx_flag = 1'b1;  // set wins over a clear in the same cycle
        end
      end
    end else begin
      st_nxt.div = st_r.div + 5'h01;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
  // --------------------------------------------------------
  // apb answer and link drive
  // --------------------------------------------------------
  assign prdata_out = st_r.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  // master clock tied to the bit clock keeps it rising-edge aligned
  assign link.mclk = st_r.bclk;  // R9 R10 R17
  assign link.tx_bit_clock = st_r.bclk;  // R14
  assign link.tx_frame_sync = st_r.ctrl[C_FS_EN] && st_r.slot == 8'h00;  // R11
  always_comb begin
    case (st_r.ctrl[C_BCR +: 2])
      2'h1:    link.rx_bit_clock = 1'b1;  // R15
      2'h2:    link.rx_bit_clock = 1'b0;  // R15
      default: link.rx_bit_clock = st_r.bclk;
    endcase
  end
  assign link.rx_frame_sync = st_r.ctrl[C_BCR +: 2] != 2'h0 ? b2 : (b2 && st_r.slot == 8'h00);
  assign link.power_down_n = st_r.ctrl[C_PDN];  // R17
  assign link.law_select = st_r.ctrl[C_LAW];
  assign link.tx_amp_noninv_in = st_r.ctrl[C_TIN +: 2];
  assign link.power_amp_in = st_r.ctrl[C_PAI];
  assign link.rx_serial_in = st_r.dr;
endmodule : codec_timing_host
`default_nettype wire

// ---- verification/codec_ctl_assertions.sv ----
// link checks between the codec timing host and the codec control
// assumes one system clock; link signals arrive as plain inputs
`timescale 1ns/1ns
`default_nettype none
module codec_ctl_assertions
  import codec_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // link
  input wire logic mclk,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire logic tx_bit_clock,
  input wire logic power_down_n,
  input wire logic tx_serial_out,
  input wire logic tx_serial_oe
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [15:0] idle_r;
  logic [7:0]  sync_age_r;
  logic [7:0]  oe_len_r;
  logic [4:0]  half_r;
  logic [3:0]  low_r;
  logic [3:0]  bit_age_r;
  logic [1:0]  rises_r;
  // run lengths and ages behind the bounded checks; half_r 0 means no edge seen yet
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_r <= '0;
      sync_age_r <= '1;
      oe_len_r <= '0;
      half_r <= '0;
      low_r <= '0;
      bit_age_r <= '1;
      rises_r <= '0;
    end else begin
      idle_r <= (tx_frame_sync | rx_frame_sync) ? '0 : idle_r + 16'(idle_r != '1);
      sync_age_r <= $rose(tx_frame_sync) ? '0 : sync_age_r + 8'(sync_age_r != '1);
      oe_len_r <= tx_serial_oe ? oe_len_r + 8'(oe_len_r != '1) : '0;
      half_r <= $changed(tx_bit_clock) ? 5'h1 : half_r + 5'(half_r != '0 && half_r != '1);
      low_r <= power_down_n ? '0 : low_r + 4'(low_r != '1);
      bit_age_r <= $rose(tx_bit_clock) ? '0 : bit_age_r + 4'(bit_age_r != '1);
      rises_r <= (low_r == 4'hf) ? '0 : rises_r + 2'($rose(tx_frame_sync) && rises_r != 2'h3);
    end
  end
  sequence pdn_low_s;
    !power_down_n [*8];
  endsequence
  pdn_float_a: assert property (pdn_low_s |-> !tx_serial_oe)
    else $error("transmit data driven while powered down");
  wake_quiet_a: assert property (rises_r < 2'h2 |-> !tx_serial_oe)
    else $error("transmit data driven too soon after power-up");
  idle_float_a: assert property (idle_r > 16'd30000 |-> !tx_serial_oe)
    else $error("transmit data driven with both syncs idle");
  word_start_a: assert property ($rose(tx_serial_oe) |-> sync_age_r < 8'd250)
    else $error("word started without a recent frame sync");
  word_len_a: assert property ($fell(tx_serial_oe) && power_down_n |-> oe_len_r inside {[8'd188:8'd196]})
    else $error("transmit word not eight bits long");
  bit_step_a: assert property (tx_serial_oe && $past(tx_serial_oe) && $changed(tx_serial_out) |-> bit_age_r < 4'd10)
    else $error("transmit bit changed away from a bit clock rise");
  mclk_align_a: assert property ($rose(tx_frame_sync) |-> ##[0:2] mclk)
    else $error("master clock not aligned to frame sync");
  bclk_half_a: assert property ($changed(tx_bit_clock) && half_r != '0 |-> half_r == BCLK_HALF)
    else $error("bit clock half period wrong");
endmodule : codec_ctl_assertions
`default_nettype wire

// ---- verification/codec_power_clock_mode_control_tb.sv ----
// self-checking bench: timing host and codec control joined by their link
// assumes the package and interface are compiled first; host is driven over apb
`timescale 1ns/1ns
`default_nettype none
module codec_power_clock_mode_control_tb;
  import codec_ctl_pkg::*;
  localparam int FR = 6144;  // system clocks per frame
  logic         clk_in = 1'b0;
  logic         nrst_in = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [7:0]   tx_word = '0;
  logic [31:0]  prdata, rdat;
  logic         pready, pslverr, err;
  logic [7:0]   rx_word, w;
  logic         mu_law, clk_en, ana_en, mid_pull, amp_drv, filt_src, pa_en, rx_mute, locked, b2_sel, b2;
  logic [4:0]   div;
  logic [1:0]   tin;
  timing_mode_t mode;
  int           err_count = 0;
  int           compares = 0;
  int           seed = 7473;
  // clock
  always #10 clk_in = ~clk_in;
  codec_link_if codec_link_if_inst ();
  codec_timing_host codec_timing_host_inst (.clk_in(clk_in), .nrst_in(nrst_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link(codec_link_if_inst));
  codec_ctl_device codec_ctl_device_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(codec_link_if_inst),
    .tx_word_in(tx_word), .tx_word_taken_out(), .rx_word_out(rx_word), .rx_word_valid_out(),
    .mu_law_out(mu_law), .clocks_en_out(clk_en), .analog_out_en_out(ana_en), .mid_ref_pullup_out(mid_pull),
    .tx_amp_drive_en_out(amp_drv), .tx_filter_from_tg_out(filt_src), .power_amp_en_out(pa_en),
    .rx_filter_to_mid_out(rx_mute), .seq_tick_out(), .prescaler_locked_out(locked),
    .prescale_div_out(div), .timing_mode_out(mode), .b2_select_out(b2_sel));
  codec_ctl_assertions codec_ctl_assertions_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .mclk(codec_link_if_inst.mclk), .tx_frame_sync(codec_link_if_inst.tx_frame_sync),
    .rx_frame_sync(codec_link_if_inst.rx_frame_sync), .tx_bit_clock(codec_link_if_inst.tx_bit_clock),
    .power_down_n(codec_link_if_inst.power_down_n), .tx_serial_out(codec_link_if_inst.tx_serial_out),
    .tx_serial_oe(codec_link_if_inst.tx_serial_oe));
  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // control word from its fields
  function automatic logic [31:0] ctrl(input logic [1:0] t, input logic pai, b, input logic [1:0] bcr,
                                       input logic law, pdn, fs);
    ctrl = 32'h0;
    ctrl[C_PDN] = pdn;
    ctrl[C_LAW] = law;
    ctrl[C_TIN +: 2] = t;
    ctrl[C_PAI] = pai;
    ctrl[C_FS_EN] = fs;
    ctrl[C_B2] = b;
    ctrl[C_BCR +: 2] = bcr;
  endfunction : ctrl
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", rdat, 32'(CTRL_RESET));
    apb(1'b1, 12'h010, 32'h1);
    chk("unmapped error", 32'(err), 32'h1);
    // every strap combination, law alternating
    for (int i = 0; i < 6; i++) begin
      tin = 2'(i % 3);
      apb(1'b1, CTRL_OFS, ctrl(tin, 1'(i / 3), 1'b1, 2'h0, 1'(i), 1'b1, 1'b1));
      repeat (20) @(posedge clk_in);
      chk("law", 32'(mu_law), 32'(i % 2));
      chk("amp drive", 32'(amp_drv), 32'(tin == 2'h0));
      chk("filter source", 32'(filt_src), 32'(tin != STRAP_LOW));
      chk("power amp", 32'(pa_en), 32'(i < 3));
    end
    // words both ways in the isdn modes, transmit words only in frame sync mode
    for (int m = 0; m < 3; m++) begin
      w = (m == 1) ? 8'hff : 8'($random(seed));
      b2 = (m == 2);
      tx_word <= (m == 2) ? 8'h00 : 8'($random(seed));
      apb(1'b1, TXW_OFS, 32'(w));
      apb(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, b2, 2'(m), 1'b1, 1'b1, 1'b1));
      repeat (FR * 5 / 2) @(posedge clk_in);
      chk("mode", 32'(mode), 32'(m));
      chk("locked", 32'(locked), 32'h1);
      chk("divider", 32'(div), 32'(256 >> RATIO_SHIFT));
      chk("mute", 32'(rx_mute), 32'(m == 0));
      apb(1'b0, RXW_OFS, 32'h0);
      chk("sent word", rdat, 32'(tx_word));
      apb(1'b0, STAT_OFS, 32'h0);
      chk("word flag", rdat, 32'h1);
      if (m != 0) begin
        chk("received word", 32'(rx_word), 32'(w));
        chk("channel", 32'(b2_sel), 32'(b2));
      end
    end
    // both syncs idle, then resume
    apb(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0));
    repeat (30000) @(posedge clk_in);
    chk("idle clocks", 32'(clk_en), 32'h0);
    chk("idle drive", 32'(codec_link_if_inst.tx_serial_oe), 32'h0);
    apb(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1));
    repeat (12) @(posedge clk_in);
    chk("clocks", 32'(clk_en), 32'h0);
    chk("analog", 32'(ana_en), 32'h0);
    chk("ref pull", 32'(mid_pull), 32'h1);
    chk("serial drive", 32'(codec_link_if_inst.tx_serial_oe), 32'h0);
    apb(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1));
    repeat (FR * 2) @(posedge clk_in);
    chk("woken clocks", 32'(clk_en), 32'h1);
    chk("woken lock", 32'(locked), 32'h1);
    stop_test();
  end
endmodule : codec_power_clock_mode_control_tb
`default_nettype wire
